// ===== rtl/clk_src_pkg.sv
// Purpose: Shared constants and types for the clock source selector.
// Assumes: Registers sit on a 32-bit APB with one aligned word each.
// Notes:   Reference and FLL clocks arrive as one-cycle tick enables.
package clk_src_pkg;
    localparam int          ADDR_W          = 8;
    localparam logic [7:0]  OFS_CONTROL_ONE = 8'h00;
    localparam logic [7:0]  OFS_CONTROL_TWO = 8'h04;
    localparam logic [7:0]  OFS_TRIM        = 8'h08;
    localparam logic [7:0]  OFS_STATUS      = 8'h0C;
    localparam logic [7:0]  RST_CONTROL_ONE = 8'h04;
    localparam logic [7:0]  RST_CONTROL_TWO = 8'h40;
    localparam logic [7:0]  RST_TRIM        = 8'h80;
    localparam logic        RST_FINE        = 1'b0;
    // Field positions in control register one.
    localparam int          SRC_HI          = 7;
    localparam int          SRC_LO          = 6;
    localparam int          REFDIV_HI       = 5;
    localparam int          REFDIV_LO       = 3;
    localparam int          REFSEL_BIT      = 2;
    localparam int          IROUT_BIT       = 1;
    localparam int          IRSTOP_BIT      = 0;
    // Field positions in control register two.
    localparam int          BUSDIV_HI       = 7;
    localparam int          BUSDIV_LO       = 6;
    localparam int          RANGE_BIT       = 5;
    localparam int          GAIN_BIT        = 4;
    localparam int          LOWPWR_BIT      = 3;
    localparam int          EXTSRC_BIT      = 2;
    localparam int          EROUT_BIT       = 1;
    localparam int          ERSTOP_BIT      = 0;
    // Source codes, shared by the select and status fields.
    localparam logic [1:0]  SRC_FLL         = 2'h0;
    localparam logic [1:0]  SRC_INT         = 2'h1;
    localparam logic [1:0]  SRC_EXT         = 2'h2;
    // FLL lock target in FLL ticks per divided reference period.
    localparam logic [9:0]  FLL_RATIO       = 10'h200;
    localparam int          DCO_W           = 9;
    localparam logic [8:0]  DCO_RESET       = 9'h100;
    localparam int          DIV_CW          = 8;
    localparam int          DIV_SW          = 4;

    typedef enum logic [1:0] {SW_IDLE, SW_WAIT_OLD, SW_WAIT_NEW} switch_state_t;

    typedef struct packed {
        logic [DIV_CW-1:0] count;
        logic              tick;
    } div_state_t;
endpackage

// ===== rtl/pow2_tick_divider.sv
// Purpose: Divides a tick enable stream by two raised to a shift code.
// Assumes: Shift code stays below the counter width plus one.
// Notes:   Output pulse is registered, so it lags the input by one cycle.
`timescale 1ns/10ps
`default_nettype none
module pow2_tick_divider
    import clk_src_pkg::*;
#(
    parameter int SW = clk_src_pkg::DIV_SW
) (
    input  wire logic          clk_in,
    input  wire logic          reset_n_in,
    input  wire logic          tick_in,
    input  wire logic [SW-1:0] shift_in,
    output var  logic          tick_out
);
    div_state_t        cur;
    div_state_t        next_cur;
    logic [DIV_CW-1:0] mask;

    always_comb begin
        next_cur      = cur;
        mask          = DIV_CW'((9'h001 << shift_in) - 9'h001);
        next_cur.tick = 1'b0;
        if (tick_in) begin
            next_cur.count = cur.count + 8'h01;
            next_cur.tick  = ((cur.count & mask) == mask);
        end
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign tick_out = cur.tick;
endmodule // pow2_tick_divider
`default_nettype wire

// ===== rtl/clk_source_select.sv
// Purpose: Register-controlled system clock source selector with dividers.
// Assumes: All clocks are modelled as one-cycle tick enables on clk_in.
// Notes:   APB slave answers in the first access cycle, no wait states.
//
// Our own choices: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module clk_source_select
    import clk_src_pkg::*;
#(
    parameter logic [7:0] TRIM_RESET = clk_src_pkg::RST_TRIM
) (
    input  wire logic                           clk_in,
    input  wire logic                           reset_n_in,
    input  wire logic                           psel_in,
    input  wire logic                           penable_in,
    input  wire logic                           pwrite_in,
    input  wire logic [clk_src_pkg::ADDR_W-1:0] paddr_in,
    input  wire logic [31:0]                    pwdata_in,
    input  wire logic [3:0]                     pstrb_in,
    output var  logic [31:0]                    prdata_out,
    output var  logic                           pready_out,
    output var  logic                           pslverr_out,
    input  wire logic                           internal_ref_tick_in,
    input  wire logic                           external_ref_tick_in,
    input  wire logic                           fll_tick_in,
    input  wire logic                           oscillator_ready_in,
    input  wire logic                           stop_mode_in,
    output var  logic                           system_clock_out,
    output var  logic                           bus_tick_out,
    output var  logic                           internal_ref_output_out,
    output var  logic                           external_ref_output_out,
    output var  logic                           internal_ref_enable_out,
    output var  logic                           external_ref_enable_out,
    output var  logic                           osc_range_out,
    output var  logic                           oscillator_gain_select_out,
    output var  logic                           external_source_choice_out,
    output var  logic                           fll_enable_out,
    output var  logic [clk_src_pkg::DCO_W-1:0]  fll_dco_code_out,
    output var  logic [7:0]                     trim_out,
    output var  logic                           fine_adjust_out
);
    typedef struct packed {
        logic [7:0]       control_one;
        logic [7:0]       control_two;
        logic [7:0]       trim;
        logic             fine;
        logic             osc_ready;
        logic [1:0]       mode_status;
        switch_state_t    sw;
        logic [1:0]       pending;
        logic [31:0]      rdata;
        logic             ready;
        logic             err;
        logic             pre_int;
        logic             pre_ext;
        logic             int_en;
        logic             ext_en;
        logic             int_out;
        logic             ext_out;
        logic             sys_out;
        logic             bus_half;
        logic             bus_tick;
        logic             fll_en;
        logic [9:0]       fll_count;
        logic [DCO_W-1:0] dco;
    } state_t;

    state_t     cur;
    state_t     next_cur;
    logic       ref_tick;
    logic       ref_div_tick;
    logic       src_tick;
    logic       sys_div_tick;
    logic [1:0] req_src;
    logic       bypass;
    logic       int_mode;
    logic       ext_mode;
    logic       access;

    // Folds the reserved select code onto the FLL code.
    function automatic logic [1:0] fold_src(input logic [1:0] code);
        fold_src = (code == 2'h3) ? SRC_FLL : code;
    endfunction

    // Picks the tick stream of one source code.
    function automatic logic pick_tick(input logic [1:0] code, input logic f,
                                       input logic i, input logic e);
        if (code == SRC_INT) begin
            pick_tick = i;
        end else if (code == SRC_EXT) begin
            pick_tick = e;
        end else begin
            pick_tick = f;
        end
    endfunction

    assign ref_tick = cur.control_one[REFSEL_BIT] ? internal_ref_tick_in
                                                  : external_ref_tick_in;

    pow2_tick_divider #(.SW(DIV_SW)) u_ref_div (
        .clk_in     (clk_in),
        .reset_n_in (reset_n_in),
        .tick_in    (ref_tick),
        .shift_in   ({1'b0, cur.control_one[REFDIV_HI:REFDIV_LO]}),
        .tick_out   (ref_div_tick)
    );

    assign src_tick = (cur.sw == SW_WAIT_NEW) ? 1'b0
                    : pick_tick(cur.mode_status, fll_tick_in,
                                internal_ref_tick_in, external_ref_tick_in);

    pow2_tick_divider #(.SW(DIV_SW)) u_bus_div (
        .clk_in     (clk_in),
        .reset_n_in (reset_n_in),
        .tick_in    (src_tick && !stop_mode_in),
        .shift_in   ({2'h0, cur.control_two[BUSDIV_HI:BUSDIV_LO]}),
        .tick_out   (sys_div_tick)
    );

    assign req_src  = fold_src(cur.control_one[SRC_HI:SRC_LO]);
    assign bypass   = (cur.mode_status != SRC_FLL);
    assign int_mode = cur.control_one[REFSEL_BIT] && (cur.mode_status != SRC_EXT);
    assign ext_mode = !cur.control_one[REFSEL_BIT] && (cur.mode_status != SRC_INT);
    assign access   = psel_in && penable_in && cur.ready;

    always_comb begin
        next_cur          = cur;
        next_cur.bus_tick = 1'b0;
        // APB setup phase: decode and prepare the answer.
        if (psel_in && !penable_in) begin
            next_cur.ready = 1'b1;
            next_cur.err   = 1'b0;
            if (paddr_in == OFS_CONTROL_ONE) begin
                next_cur.rdata = {24'h0, cur.control_one};
            end else if (paddr_in == OFS_CONTROL_TWO) begin
                next_cur.rdata = {24'h0, cur.control_two};
            end else if (paddr_in == OFS_TRIM) begin
                next_cur.rdata = {24'h0, cur.trim};
            end else if (paddr_in == OFS_STATUS) begin
                next_cur.rdata = {28'h0, cur.mode_status, cur.osc_ready, cur.fine};
            end else begin
                next_cur.rdata = 32'h0;
                next_cur.err   = 1'b1;
            end
        end
        if (access) begin
            next_cur.ready = 1'b0;
            next_cur.err   = 1'b0;
            if (pwrite_in && pstrb_in[0]) begin
                if (paddr_in == OFS_CONTROL_ONE) begin
                    next_cur.control_one = pwdata_in[7:0];
                end else if (paddr_in == OFS_CONTROL_TWO) begin
                    next_cur.control_two = pwdata_in[7:0];
                end else if (paddr_in == OFS_TRIM) begin
                    next_cur.trim = pwdata_in[7:0];
                end else if (paddr_in == OFS_STATUS) begin
                    // only the fine bit is writable
                    next_cur.fine = pwdata_in[0];
                end
            end
        end
        case (cur.sw)
            SW_IDLE: begin
                if (req_src != cur.mode_status) begin
                    next_cur.pending = req_src;
                    next_cur.sw      = SW_WAIT_OLD;
                end
            end
            SW_WAIT_OLD: begin
                if (pick_tick(cur.mode_status, fll_tick_in, internal_ref_tick_in,
                              external_ref_tick_in)) begin
                    next_cur.sw = SW_WAIT_NEW;
                end
            end
            SW_WAIT_NEW: begin
                if (pick_tick(cur.pending, fll_tick_in, internal_ref_tick_in,
                              external_ref_tick_in)) begin
                    next_cur.mode_status = cur.pending;
                    next_cur.sw          = SW_IDLE;
                end
            end
            default: begin
                next_cur.sw = SW_IDLE;
            end
        endcase
        // system clock and half-rate bus tick
        if (sys_div_tick) begin
            next_cur.sys_out  = !cur.sys_out;
            next_cur.bus_half = !cur.bus_half;
            next_cur.bus_tick = cur.bus_half;
        end
        if (!stop_mode_in) begin
            next_cur.pre_int = int_mode;
            next_cur.pre_ext = ext_mode;
            next_cur.int_en  = cur.control_one[IROUT_BIT] || int_mode;
            next_cur.ext_en  = cur.control_two[EROUT_BIT] || ext_mode;
        end else begin
            next_cur.int_en = cur.control_one[IRSTOP_BIT]
                              && (cur.control_one[IROUT_BIT] || cur.pre_int);
            next_cur.ext_en = cur.control_two[ERSTOP_BIT]
                              && (cur.control_two[EROUT_BIT] || cur.pre_ext);
        end
        if (!cur.control_one[IROUT_BIT] || !cur.int_en) begin
            next_cur.int_out = 1'b0;
        end else if (internal_ref_tick_in) begin
            next_cur.int_out = !cur.int_out;
        end
        if (!cur.control_two[EROUT_BIT] || !cur.ext_en) begin
            next_cur.ext_out = 1'b0;
        end else if (external_ref_tick_in) begin
            next_cur.ext_out = !cur.ext_out;
        end
        // Oscillator ready: set once running, cleared only by its enables.
        if (!cur.control_two[EXTSRC_BIT]
            || (!cur.control_two[EROUT_BIT] && !ext_mode)) begin
            next_cur.osc_ready = 1'b0;
        end else if (oscillator_ready_in) begin
            next_cur.osc_ready = 1'b1;
        end
        // FLL off in stop or low power bypass
        next_cur.fll_en = !stop_mode_in
                          && !(bypass && cur.control_two[LOWPWR_BIT]);
        if (!cur.fll_en) begin
            next_cur.fll_count = 10'h0;
        end else if (ref_div_tick) begin
            next_cur.fll_count = 10'h0;
            if (cur.fll_count < FLL_RATIO && cur.dco != '1) begin
                next_cur.dco = cur.dco + 9'h001;
            end else if (cur.fll_count > FLL_RATIO && cur.dco != '0) begin
                next_cur.dco = cur.dco - 9'h001;
            end
        end else if (fll_tick_in && cur.fll_count != 10'h3FF) begin
            next_cur.fll_count = cur.fll_count + 10'h001;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            cur             <= '0;
            cur.control_one <= RST_CONTROL_ONE;
            cur.control_two <= RST_CONTROL_TWO;
            cur.trim        <= TRIM_RESET;
            cur.fine        <= RST_FINE;
            cur.mode_status <= SRC_FLL;
            cur.sw          <= SW_IDLE;
            cur.dco         <= DCO_RESET;
        end else begin
            cur <= next_cur;
        end
    end

    assign prdata_out                 = cur.rdata;
    assign pready_out                 = cur.ready;
    assign pslverr_out                = cur.err;
    assign system_clock_out           = cur.sys_out;
    assign bus_tick_out               = cur.bus_tick;
    assign internal_ref_output_out    = cur.int_out;
    assign external_ref_output_out    = cur.ext_out;
    assign internal_ref_enable_out    = cur.int_en;
    assign external_ref_enable_out    = cur.ext_en;
    assign osc_range_out              = cur.control_two[RANGE_BIT];
    assign oscillator_gain_select_out = cur.control_two[GAIN_BIT];
    assign external_source_choice_out = cur.control_two[EXTSRC_BIT];
    assign fll_enable_out             = cur.fll_en;
    assign fll_dco_code_out           = cur.dco;
    assign trim_out                   = cur.trim;
    assign fine_adjust_out            = cur.fine;

    AST_STATUS_ZERO: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        pready_out && paddr_in == OFS_STATUS |-> prdata_out[31:4] == 28'h0)
        else $error("status upper bits not zero");
    AST_STATUS_NO_JUMP: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        $changed(cur.mode_status) |-> $past(cur.sw) == SW_WAIT_NEW)
        else $error("mode status changed without handover");
    AST_RESERVED_FOLD: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        cur.sw == SW_IDLE && cur.control_one[SRC_HI:SRC_LO] == 2'h3
        && cur.mode_status != SRC_FLL |=> cur.pending == SRC_FLL)
        else $error("reserved select not treated as FLL");
    AST_GAP_ON_SWITCH: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        cur.sw == SW_WAIT_NEW |=> !sys_div_tick)
        else $error("tick passed during handover gap");
    AST_LOWPWR_FLL: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        bypass && cur.control_two[LOWPWR_BIT] |=> !fll_enable_out)
        else $error("FLL running in low power bypass");
    AST_STOP_INT: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        stop_mode_in && $past(stop_mode_in) && !cur.control_one[IRSTOP_BIT]
        |=> !internal_ref_enable_out)
        else $error("internal reference kept in stop");
    AST_STOP_EXT: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        stop_mode_in && !cur.control_two[ERSTOP_BIT] |=> !external_ref_enable_out)
        else $error("external reference kept in stop");
    AST_INT_OUT_OFF: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        !cur.control_one[IROUT_BIT] |=> !internal_ref_output_out)
        else $error("internal reference output active while disabled");
    AST_EXT_OUT_OFF: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        !cur.control_two[EROUT_BIT] |=> !external_ref_output_out)
        else $error("external reference output active while disabled");
    AST_BUS_HALF: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        bus_tick_out |-> !cur.bus_half && $past(sys_div_tick))
        else $error("bus tick not at half system rate");
    AST_FLL_STEER: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        cur.fll_en && ref_div_tick && cur.fll_count < FLL_RATIO && cur.dco != '1
        |=> fll_dco_code_out == $past(cur.dco) + 9'h001)
        else $error("FLL did not speed up below target");

    COV_SWITCH_INT: cover property (@(posedge clk_in) disable iff (!reset_n_in)
        cur.sw == SW_WAIT_NEW ##1 cur.mode_status == SRC_INT);
    COV_SWITCH_EXT: cover property (@(posedge clk_in) disable iff (!reset_n_in)
        cur.sw == SW_WAIT_NEW ##1 cur.mode_status == SRC_EXT);
    COV_STOP_KEEP: cover property (@(posedge clk_in) disable iff (!reset_n_in)
        stop_mode_in && internal_ref_enable_out);
    COV_BUS_TICK: cover property (@(posedge clk_in) disable iff (!reset_n_in)
        bus_tick_out);
endmodule // clk_source_select
`default_nettype wire

// ===== tb/osc_partner.sv
// Purpose: Reference, crystal and FLL clock model facing the source selector.
// Assumes: Every clock is a one-cycle tick pulse on the bench clock.
// Notes:   The crystal reports ready a fixed count after it is requested.
`timescale 1ns/10ps
`default_nettype none
module osc_partner #(
    parameter int IP = 4,
    parameter int EP = 3,
    parameter int FP = 2
) (
    input  wire logic clk_in,
    input  wire logic reset_n_in,
    input  wire logic int_enable_in,
    input  wire logic fll_enable_in,
    input  wire logic crystal_in,
    output var  logic int_tick_out,
    output var  logic ext_tick_out,
    output var  logic fll_tick_out,
    output var  logic ready_out
);
    int cnt;
    int warm;
    always_ff @(posedge clk_in) begin
        cnt  <= reset_n_in ? cnt + 1 : 0;
        warm <= (reset_n_in && crystal_in) ? ((warm < 8) ? warm + 1 : warm) : 0;
    end
    // Internal and FLL clocks stand still unless the block enables them.
    assign int_tick_out = int_enable_in && (cnt % IP == 0);
    assign fll_tick_out = fll_enable_in && (cnt % FP == 0);
    assign ext_tick_out = (cnt % EP == 0);
    assign ready_out    = (warm == 8);
endmodule // osc_partner
`default_nettype wire

// ===== tb/testbench.sv
// Purpose: Self-checking bench for the clock source selector.
// Assumes: Zero-wait APB slave; FLL clock ticks every second cycle.
// Notes:   Register rows first, then switching, dividers and stop.
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import clk_src_pkg::*;
    logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, stop = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    logic pready, pslverr, it, et, ft, rdy, sys, bt, iro, ero, ien, een;
    logic rng, gain, xsel, fen;
    int n_mismatch = 0, n_compared = 0, cyc = 0, n;
    typedef struct {logic [7:0] a; logic [7:0] w; logic [7:0] r; logic [2:0] o;} row_t;
    row_t rows[8] = '{'{OFS_TRIM, 8'h5A, 8'h5A, 3'h0}, '{OFS_STATUS, 8'hFF, 8'h01, 3'h0},
        '{OFS_STATUS, 8'h00, 8'h00, 3'h0}, '{OFS_CONTROL_TWO, 8'h70, 8'h70, 3'h6},
        '{OFS_CONTROL_TWO, 8'h44, 8'h44, 3'h1}, '{OFS_CONTROL_TWO, 8'h40, 8'h40, 3'h0},
        '{OFS_CONTROL_ONE, 8'h3C, 8'h3C, 3'h0}, '{OFS_CONTROL_ONE, 8'h04, 8'h04, 3'h0}};
    clk_source_select clk_source_select_inst (.clk_in(clk), .reset_n_in(rst_n),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .pstrb_in(4'hF), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .internal_ref_tick_in(it), .external_ref_tick_in(et),
        .fll_tick_in(ft), .oscillator_ready_in(rdy), .stop_mode_in(stop),
        .system_clock_out(sys), .bus_tick_out(bt), .internal_ref_output_out(iro),
        .external_ref_output_out(ero), .internal_ref_enable_out(ien),
        .external_ref_enable_out(een), .osc_range_out(rng),
        .oscillator_gain_select_out(gain), .external_source_choice_out(xsel),
        .fll_enable_out(fen), .fll_dco_code_out(), .trim_out(), .fine_adjust_out());
    osc_partner osc_partner_inst (.clk_in(clk), .reset_n_in(rst_n), .int_enable_in(ien),
        .fll_enable_in(fen), .crystal_in(xsel), .int_tick_out(it), .ext_tick_out(et),
        .fll_tick_out(ft), .ready_out(rdy));
    task automatic complete_run();
        $display("mismatches %0d of %0d compared", n_mismatch, n_compared);
        if (n_mismatch == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, 24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 8'h00, r, e);
        chk({e, r}, {1'b0, exp});
    endtask
    task automatic poll(input logic [7:0] exp);
        logic [31:0] r;
        logic e;
        repeat (40) begin
            apb(1'b0, OFS_STATUS, 8'h00, r, e);
            if (r === {24'h0, exp}) break;
        end
        chk(r, {24'h0, exp});
    endtask
    task automatic highs(input logic ext, output int k);
        k = 0;
        @(posedge clk);
        repeat (40) begin
            @(negedge clk);
            k += int'(ext ? ero : iro);
        end
    endtask
    task automatic gap(output int k);
        k = 0;
        do @(negedge clk); while (bt !== 1'b1);
        do begin @(negedge clk); k++; end while (bt !== 1'b1 && k < 200);
    endtask
    initial forever #5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            complete_run();
        end
    end
    initial begin
        logic [31:0] r;
        logic e;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(OFS_CONTROL_ONE, 32'h04);
        rd(OFS_CONTROL_TWO, 32'h40);
        rd(OFS_STATUS, 32'h00);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a, {24'h0, rows[i].r});
            chk({rng, gain, xsel}, rows[i].o);
        end
        apb(1'b0, 8'h10, 8'h00, r, e);
        chk({e, r}, {1'b1, 32'h0});
        wr(OFS_CONTROL_ONE, 8'h44);
        poll(8'h04);
        wr(OFS_CONTROL_ONE, 8'hC4);
        poll(8'h00);
        for (int b = 0; b < 4; b++) begin
            wr(OFS_CONTROL_TWO, 8'(b << 6));
            gap(n);
            gap(n);
            chk(n, 4 << b);
        end
        highs(1'b0, n);
        chk(n, 0);
        wr(OFS_CONTROL_ONE, 8'h06);
        highs(1'b0, n);
        chk(n != 0, 1);
        wr(OFS_CONTROL_TWO, 8'h46);
        highs(1'b1, n);
        chk(n != 0, 1);
        poll(8'h02);
        wr(OFS_CONTROL_TWO, 8'h40);
        highs(1'b1, n);
        chk(n, 0);
        rd(OFS_STATUS, 32'h00);
        wr(OFS_CONTROL_ONE, 8'h05);
        stop <= 1'b1;
        repeat (4) @(posedge clk);
        chk({ien, een}, 2'b10);
        stop <= 1'b0;
        wr(OFS_CONTROL_ONE, 8'h04);
        stop <= 1'b1;
        repeat (4) @(posedge clk);
        chk({ien, een}, 2'b00);
        stop <= 1'b0;
        wr(OFS_CONTROL_ONE, 8'h80);
        poll(8'h08);
        wr(OFS_CONTROL_TWO, 8'h49);
        repeat (2) @(posedge clk);
        chk(fen, 0);
        stop <= 1'b1;
        repeat (4) @(posedge clk);
        chk({ien, een}, 2'b01);
        {stop, rst_n} <= 2'b00;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(OFS_CONTROL_ONE, 32'h04);
        rd(OFS_STATUS, 32'h00);
        complete_run();
    end
endmodule // testbench
`default_nettype wire
